//--- core/pdwc_pkg.sv
// power-down and wake-route control: shared constants and types
// assumes a 20 MHz cpu clock and a 32-bit ahb-lite register bus
package pdwc_pkg;
   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_WAKE_ROUTE = 16'hFF94;
   localparam logic [15:0] IDX_MISC_ZERO = 16'hFFF1;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'hFFA0;
   localparam logic [15:0] IDX_IRQ_MASK = 16'hFFA1;
   localparam logic [15:0] IDX_PWR_STATE = 16'hFFA2;
   localparam logic [7:0] RST_WAKE_ROUTE = 8'h00;
   localparam logic [7:0] RST_MISC_ZERO = 8'h00;
   // field positions
   localparam int BIT_ROUTE_SEL = 7;
   localparam int BIT_KP_EN = 1;
   localparam int BIT_KP_FLAG = 0;
   localparam int BIT_PWR_REQ = 7;
   localparam int BIT_LOOPBACK = 1;
   localparam int BIT_PIN_SEL = 0;
   localparam int IRQ_W = 3;
   localparam int IRQ_OSC_OFF = 0;
   localparam int IRQ_WAKE_DONE = 1;
   localparam int IRQ_KEYPAD = 2;
   // timing in cpu clocks
   localparam int SHUTDOWN_CLKS = 32;
   localparam int SETTLE_CLKS = 512;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef enum logic [1:0] {PS_RUN, PS_WAIT, PS_OFF, PS_SETTLE} pdwc_state_type;

   typedef struct packed {
      logic keypad;
      logic card;
      logic [7:0] user;
   } pdwc_wake_src_type;

   typedef struct packed {
      logic osc_pll_enable;
      logic stepup_enable;
      logic cpu_hold;
      logic power_save_override;
   } pdwc_power_out_type;
endpackage

//--- core/pdwc_sync.sv
// two-flop synchroniser, one stage pair per bit
// assumes inputs are asynchronous levels from pins
`timescale 1ns/100ps
module pdwc_sync #(
   parameter int W = 1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               meta_r[i] <= 1'b0;
               sync_r[i] <= 1'b0;
            end else begin
               meta_r[i] <= async_in[i];
               sync_r[i] <= meta_r[i];
            end
         end
      end
   endgenerate

   assign sync_out = sync_r;
endmodule

//--- core/pdwc_delay.sv
// cycle delay: done rises after start has been high for n cycles
// assumes start stays high while waiting; dropping start restarts
`timescale 1ns/100ps
module pdwc_delay #(
   parameter int N = 32,
   parameter int CW = 10
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start,
   output logic done
);
   logic [CW-1:0] cnt_r;
   localparam logic [CW-1:0] LAST = CW'(N - 1);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= '0;
      end else if (!start) begin
         cnt_r <= '0;
      end else if (cnt_r != LAST) begin
         cnt_r <= cnt_r + CW'(1);
      end
   end

   assign done = start && (cnt_r == LAST);
endmodule

//--- core/pdwc_top.sv
// power-down entry and wake-route control with ahb-lite registers
// assumes one cpu clock, a master that idles between transfers,
// and firmware that stops the cpu right after requesting power-down
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/100ps
module pdwc_top #(
   parameter int SETTLE = pdwc_pkg::SETTLE_CLKS
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire pdwc_pkg::pdwc_wake_src_type wake_src,
   input wire logic bus_supply_present,
   input wire logic onoff_is_on,
   output logic keypad_irq_line,
   output logic card_irq_line,
   output logic ext_irq_line_zero,
   output pdwc_pkg::pdwc_power_out_type pwr,
   output logic uart_loopback,
   output logic serial_pin_select,
   output logic irq
);
   import pdwc_pkg::*;

   pdwc_wake_src_type src_s;
   logic bus_sup_s;
   logic onoff_s;
   logic kp_prev_r;
   logic kp_event;
   logic [7:0] wake_route_r;
   logic [7:0] misc_zero_r;
   logic [IRQ_W-1:0] irq_status_r;
   logic [IRQ_W-1:0] irq_mask_r;
   logic [IRQ_W-1:0] irq_set;
   pdwc_state_type state_r;
   logic wr_pend_r;
   logic [15:0] wr_idx_r;
   logic addr_ok;
   logic take;
   logic [15:0] idx;
   logic wr_route;
   logic wr_misc;
   logic rd_route;
   logic route_sel;
   logic wake_or;
   logic shut_done;
   logic settle_start;
   logic settle_done;
   logic route_line_zero;
   logic [31:0] rd_mux;

   pdwc_sync #(
      .W(12)
   ) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .async_in({wake_src, bus_supply_present, onoff_is_on}),
      .sync_out({src_s, bus_sup_s, onoff_s})
   );

   // ---- bus slave: address phase captured, write applied in data phase
   assign idx = haddr[17:2];
   assign addr_ok = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0);
   assign take = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign rd_route = take && !hwrite && addr_ok && (idx == IDX_WAKE_ROUTE);
   assign wr_route = wr_pend_r && (wr_idx_r == IDX_WAKE_ROUTE);
   assign wr_misc = wr_pend_r && (wr_idx_r == IDX_MISC_ZERO);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_idx_r <= 16'h0000;
      end else begin
         wr_pend_r <= take && hwrite && addr_ok;
         wr_idx_r <= idx;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (addr_ok) begin
         case (idx)
            IDX_WAKE_ROUTE: rd_mux[7:0] = wake_route_r;
            IDX_MISC_ZERO: rd_mux[7:0] = misc_zero_r;
            IDX_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_status_r;
            IDX_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_r;
            IDX_PWR_STATE: rd_mux[1:0] = state_r;
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   end

   // read data sampled at the address phase so the clear-on-read below
   // cannot disturb the value software sees
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         hrdata <= rd_mux;
      end
   end

   // ---- wake-route / keypad control register
   assign kp_event = src_s.keypad && !kp_prev_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         kp_prev_r <= 1'b0;
      end else begin
         kp_prev_r <= src_s.keypad;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wake_route_r <= RST_WAKE_ROUTE;
      end else begin
         if (wr_route) begin
            wake_route_r[BIT_ROUTE_SEL] <= hwdata[BIT_ROUTE_SEL];
            wake_route_r[BIT_KP_EN] <= hwdata[BIT_KP_EN];
            wake_route_r[BIT_KP_FLAG] <= hwdata[BIT_KP_FLAG];
         end
         if (rd_route) begin
            wake_route_r[BIT_ROUTE_SEL] <= 1'b0;
         end
         // event beats a software clear in the same cycle
         if (kp_event) begin
            wake_route_r[BIT_KP_FLAG] <= 1'b1;
         end
      end
   end

   assign route_sel = wake_route_r[BIT_ROUTE_SEL];

   // ---- miscellaneous control zero; request bit self-clears on the last settle clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         misc_zero_r <= RST_MISC_ZERO;
      end else if (wr_misc) begin
         misc_zero_r[BIT_PWR_REQ] <= hwdata[BIT_PWR_REQ];
         misc_zero_r[BIT_LOOPBACK] <= hwdata[BIT_LOOPBACK];
         misc_zero_r[BIT_PIN_SEL] <= hwdata[BIT_PIN_SEL];
      end else if (state_r == PS_SETTLE && settle_done) begin
         misc_zero_r[BIT_PWR_REQ] <= 1'b0;
      end
   end

   assign uart_loopback = misc_zero_r[BIT_LOOPBACK];
   assign serial_pin_select = misc_zero_r[BIT_PIN_SEL];

   // ---- power sequencing
   assign wake_or = src_s.keypad | src_s.card | (|src_s.user);

   pdwc_delay #(
      .N(SHUTDOWN_CLKS),
      .CW(6)
   ) u_shut (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(state_r == PS_WAIT),
      .done(shut_done)
   );

   // settle count only runs once clocks are back: never in wait or off
   assign settle_start = (state_r == PS_SETTLE)
                         || (state_r == PS_RUN && route_sel && wake_or);

   pdwc_delay #(
      .N(SETTLE),
      .CW(10)
   ) u_settle (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(settle_start),
      .done(settle_done)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= PS_RUN;
      end else begin
         case (state_r)
            PS_RUN: begin
               if (wr_misc && hwdata[BIT_PWR_REQ]) begin
                  state_r <= PS_WAIT;
               end
            end
            PS_WAIT: begin
               if (shut_done) begin
                  state_r <= PS_OFF;
               end
            end
            PS_OFF: begin
               if (wake_or) begin
                  state_r <= PS_SETTLE;
               end
            end
            PS_SETTLE: begin
               if (settle_done) begin
                  state_r <= PS_RUN;
               end
            end
            default: state_r <= PS_RUN;
         endcase
      end
   end

   assign pwr.osc_pll_enable = (state_r != PS_OFF);
   // standby only unless both the bus supply and the switch are off
   assign pwr.stepup_enable = !(state_r == PS_OFF && !bus_sup_s && !onoff_s);
   assign pwr.cpu_hold = (state_r == PS_OFF) || (state_r == PS_SETTLE);
   assign pwr.power_save_override = misc_zero_r[BIT_PWR_REQ];

   // ---- interrupt routing
   // a wake from off routes to line zero even if the select bit was
   // cleared by a read meanwhile; that is the only way back to run
   assign route_line_zero = settle_done;
   assign ext_irq_line_zero = route_sel ? route_line_zero
                              : ((state_r == PS_SETTLE) ? route_line_zero
                              : (|src_s.user));
   assign card_irq_line = src_s.card && !route_sel;
   assign keypad_irq_line = wake_route_r[BIT_KP_FLAG] && wake_route_r[BIT_KP_EN]
                            && !route_sel;

   // ---- status / mask / interrupt
   assign irq_set[IRQ_OSC_OFF] = (state_r == PS_WAIT) && shut_done;
   assign irq_set[IRQ_WAKE_DONE] = (state_r == PS_SETTLE) && settle_done;
   assign irq_set[IRQ_KEYPAD] = kp_event;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_status_r <= '0;
         irq_mask_r <= '0;
      end else begin
         if (wr_pend_r && wr_idx_r == IDX_IRQ_MASK) begin
            irq_mask_r <= hwdata[IRQ_W-1:0];
         end
         if (wr_pend_r && wr_idx_r == IDX_IRQ_STATUS) begin
            irq_status_r <= (irq_status_r & ~hwdata[IRQ_W-1:0]) | irq_set;
         end else begin
            irq_status_r <= irq_status_r | irq_set;
         end
      end
   end

   assign irq = |(irq_status_r & irq_mask_r);

   // cycles spent in settle, kept apart from the delay counter so the
   // check below does not lean on the logic it guards
   logic [9:0] settle_cyc_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         settle_cyc_r <= 10'h000;
      end else if (state_r == PS_SETTLE) begin
         settle_cyc_r <= settle_cyc_r + 10'h001;
      end else begin
         settle_cyc_r <= 10'h000;
      end
   end

   // ---- checks
   AST_ROUTE_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_route |=> !route_sel)
      else $error("route select survived a read");
   AST_SHUT_32: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(state_r == PS_WAIT) |-> pwr.osc_pll_enable [*8] ##25 !pwr.osc_pll_enable)
      else $error("oscillator not off 32 clocks after request");
   AST_SHUT_NOT_EARLY: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(state_r == PS_WAIT) |-> ##31 pwr.osc_pll_enable)
      else $error("oscillator off too early");
   AST_HOLD_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_r == PS_OFF && !wake_or) |=> pwr.cpu_hold)
      else $error("cpu released without a wake");
   AST_OVERRIDE: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_r != PS_RUN) |-> pwr.power_save_override)
      else $error("override dropped during power-down");
   AST_SETTLE_512: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_r == PS_SETTLE) |-> (ext_irq_line_zero == (settle_cyc_r == 10'(SETTLE - 1))))
      else $error("line zero not raised on the last settle clock");
   AST_CLOCKS_FIRST: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_r == PS_SETTLE) |-> pwr.osc_pll_enable && pwr.stepup_enable)
      else $error("settle counting without power and clocks");
   AST_STEPUP: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_r == PS_OFF && (bus_sup_s || onoff_s)) |-> pwr.stepup_enable)
      else $error("converter off while in standby conditions");
   AST_ROUTED_AWAY: assert property (@(posedge hclk) disable iff (!hresetn)
      route_sel |-> !card_irq_line && !keypad_irq_line)
      else $error("routed source still on its own line");
   AST_KP_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
      kp_event |=> wake_route_r[BIT_KP_FLAG])
      else $error("keypad event lost");
   AST_KP_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
      !wake_route_r[BIT_KP_EN] |-> !keypad_irq_line)
      else $error("keypad request without enable");
   AST_UART: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(wr_misc && hwdata[BIT_LOOPBACK]) |=> uart_loopback)
      else $error("loopback not applied");
   AST_WAKE_OR: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_r == PS_OFF && (|src_s.user)) |=> (state_r == PS_SETTLE))
      else $error("user pin wake ignored");
   AST_CARD_PASS: assert property (@(posedge hclk) disable iff (!hresetn)
      !route_sel |-> (card_irq_line == src_s.card))
      else $error("card request not passed on its own line");
   AST_USER_PASS: assert property (@(posedge hclk) disable iff (!hresetn)
      (!route_sel && state_r != PS_SETTLE) |-> (ext_irq_line_zero == (|src_s.user)))
      else $error("user pins not passed on line zero");
   AST_STEPUP_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_r == PS_OFF && !bus_sup_s && !onoff_s) |-> !pwr.stepup_enable)
      else $error("converter left on in full off");
   AST_ENTER_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_r == PS_RUN && wr_misc && hwdata[BIT_PWR_REQ]) |=>
         (state_r == PS_WAIT && pwr.power_save_override))
      else $error("request write did not start power-down");
   AST_WAIT_HOLDS: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_r == PS_WAIT && !shut_done) |=> (state_r == PS_WAIT))
      else $error("shutdown window cut short");
   AST_RUN_FREE: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_r == PS_RUN) |-> !pwr.cpu_hold)
      else $error("cpu held while running");
endmodule

//--- verif/pdwc_cpu_model.sv
// cpu-side bus model: single-word ahb-lite transfers from firmware
// assumes the one slave's hreadyout is returned as hready
`timescale 1ns/100ps
module pdwc_cpu_model
   import pdwc_pkg::*;
(
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   output logic bus_tmo
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      bus_tmo = 1'b0;
   end

   // one bounded wait for hready at a rising edge
   task automatic edge_ready();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 100);
      if (n >= 100) bus_tmo <= 1'b1;
   endtask

   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      edge_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      edge_ready();
      q = hrdata;
   endtask

   // firmware order: route select first, then the request; afterwards the
   // core is stopped, so no further bus traffic until wake
   task automatic power_down(input logic [31:0] a_route, input logic [31:0] a_misc);
      logic [31:0] q;
      xfer(a_route, 1'b1, 32'h80, q);
      xfer(a_misc, 1'b1, 32'h80, q);
   endtask
endmodule

//--- verif/tb_power_down_wake_control.sv
// self-checking bench for the power-down and wake-route block
// assumes settle count shortened to 8 clocks and a 50 ns clock
`timescale 1ns/100ps
module tb_power_down_wake_control;
   import pdwc_pkg::*;
   localparam int SET_N = 8;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, bus_tmo;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic bus_supply_present, onoff_is_on, keypad_irq_line, card_irq_line;
   logic ext_irq_line_zero, uart_loopback, serial_pin_select, irq;
   pdwc_wake_src_type wake_src;
   pdwc_power_out_type pwr;
   int err_total, checks, n;
   logic [31:0] a_rt, a_mz, a_st, a_mk;

   pdwc_top #(.SETTLE(SET_N)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .wake_src(wake_src), .bus_supply_present(bus_supply_present),
      .onoff_is_on(onoff_is_on), .keypad_irq_line(keypad_irq_line),
      .card_irq_line(card_irq_line), .ext_irq_line_zero(ext_irq_line_zero), .pwr(pwr),
      .uart_loopback(uart_loopback), .serial_pin_select(serial_pin_select), .irq(irq));

   pdwc_cpu_model cpu_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .bus_tmo(bus_tmo));

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask

   task automatic give_verdict();
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   always @(posedge bus_tmo) begin
      err_total++;
      give_verdict();
   end

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      cpu_u.xfer(a, 1'b1, d, q);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      cpu_u.xfer(a, 1'b0, 32'h0, q);
      chk(q, exp);
   endtask

   // counts edges until the chosen output reaches v; bounded
   task automatic wait_sig(input int sel, input logic v, output int c);
      logic s;
      c = 0;
      do begin
         @(posedge hclk);
         #1;
         c++;
         s = (sel == 0) ? pwr.osc_pll_enable : ext_irq_line_zero;
      end while (s !== v && c < 2000);
      if (c >= 2000) begin
         err_total++;
         give_verdict();
      end
   endtask

   task automatic steps(input int k);
      repeat (k) @(posedge hclk);
   endtask

   initial begin
      hresetn = 1'b0;
      wake_src = '0;
      bus_supply_present = 1'b0;
      onoff_is_on = 1'b0;
      err_total = 0;
      checks = 0;
      a_rt = {14'h0, IDX_WAKE_ROUTE, 2'h0};
      a_mz = {14'h0, IDX_MISC_ZERO, 2'h0};
      a_st = {14'h0, IDX_IRQ_STATUS, 2'h0};
      a_mk = {14'h0, IDX_IRQ_MASK, 2'h0};
      steps(20);
      hresetn <= 1'b1;
      steps(1);
      rd(a_rt, {24'h0, RST_WAKE_ROUTE});
      rd(a_mz, {24'h0, RST_MISC_ZERO});
      rd(32'h0000_0100, 32'h0);
      rd({14'h0, IDX_PWR_STATE, 2'h0}, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      $display("test reset_values done");
      wr(a_mz, 32'h03);
      #1;
      chk({30'h0, uart_loopback, serial_pin_select}, 32'h3);
      wr(a_mz, 32'h00);
      $display("test misc_bits done");
      wr(a_rt, 32'h80);
      rd(a_rt, 32'h80);
      rd(a_rt, 32'h00);
      $display("test route_clear done");
      wake_src <= '{keypad: 1'b1, card: 1'b1, user: 8'h01};
      steps(4);
      chk({31'h0, keypad_irq_line}, 32'h0);
      chk({31'h0, card_irq_line}, 32'h1);
      chk({31'h0, ext_irq_line_zero}, 32'h1);
      // keep the flag bit set: the write stores bit 0 as given
      wr(a_rt, 32'h03);
      #1;
      chk({31'h0, keypad_irq_line}, 32'h1);
      rd(a_st, 32'h4);
      wake_src <= '0;
      wr(a_st, 32'h4);
      wr(a_rt, 32'h00);
      $display("test keypad done");
      // pass 0 reaches full off, pass 1 only standby
      for (int p = 0; p < 2; p++) begin
         bus_supply_present <= p[0];
         steps(3);
         cpu_u.power_down(a_rt, a_mz);
         wait_sig(0, 1'b0, n);
         chk(n, 32);
         chk({29'h0, pwr.cpu_hold, pwr.power_save_override, pwr.stepup_enable},
             {29'h0, 2'h3, p[0]});
         if (p == 0) wake_src.user[3] <= 1'b1;
         else wake_src.card <= 1'b1;
         wait_sig(0, 1'b1, n);
         chk({31'h0, pwr.cpu_hold}, 32'h1);
         wait_sig(1, 1'b1, n);
         chk(n, SET_N - 1);
         chk({31'h0, card_irq_line}, 32'h0);
         wake_src <= '0;
         steps(2);
         chk({31'h0, pwr.cpu_hold}, 32'h0);
         rd(a_st, 32'h3);
         wr(a_mk, 32'h3);
         #1;
         chk({31'h0, irq}, 32'h1);
         wr(a_st, 32'h3);
         #1;
         chk({31'h0, irq}, 32'h0);
         wr(a_mk, 32'h0);
      end
      $display("test power_cycles done");
      give_verdict();
   end
endmodule
